// File: lfl_defines.vh
// Constants for the LED fault latch and shutdown controller
`ifndef LFL_DEFINES_VH
`define LFL_DEFINES_VH

// ------------------------------------------------------------
// Clock and timebase
// ------------------------------------------------------------
// Clocks per 1 us tick at a 4 ns period
`define LFL_TICK_CYCLES 16'h00fa
// Filter length in 1 us ticks, 16 ms
`define LFL_FILTER_TICKS 16'h3e80
// Clocks per switching cycle
`define LFL_SW_DIV 16'h007d
// Soft-start length in switching cycles
`define LFL_SOFT_TICKS 8'h40
// Foreign pull length before disable
`define LFL_EXT_FAULT_CYCLES 4'h8

// ------------------------------------------------------------
// Register offsets and fields
// ------------------------------------------------------------
`define LFL_ADDR_STATUS 4'h0
`define LFL_ADDR_MASK 4'h4
`define LFL_ADDR_STATE 4'h8
`define LFL_ST_SHORT 0
`define LFL_ST_EXTF 1
`define LFL_ST_CLEAR 2
`define LFL_ST_SLEEP 3
`define LFL_STATUS_RST 4'h0
`define LFL_MASK_RST 4'h0

`endif

// File: lfl_tick_div.v
// Enable pulse divider for the controller timebases
`timescale 1ns/1ps
module lfl_tick_div #(
   parameter [15:0] DIV = 16'h0002
) (
   clk,
   reset_n,
   run,
   tick
);
   input wire clk;
   input wire reset_n;
   input wire run;
   output reg tick;

   reg [15:0] cnt_ff; // Cycle counter

   // ------------------------------------------------------------
   // Counter and one-cycle pulse
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n || !run) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_ff == DIV - 16'h0001) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// File: lfl_ctrl.v
// Fault latch, shutdown and partial-short supervision of a four-string LED driver
//
// Function
// - Sinks on only while enable and dimming high
// - Enable low past filter time enters sleep
// - First enable rise after sleep clears faults
// - Soft start after wake on next dimming high
// - Dimming low past filter stays awake; clears the fault latch in standard only
// - Bias and clock stay on; soft start follows
// - Open-drain fault pin pulls low on fault
// - All-out: external fault over 8 cycles disables
// - String above short threshold leaves regulation
// - Standard: shorted strings off, fault latched low
// - All-out: short turns all off, latched
// - Short detect armed only with regulating string
`timescale 1ns/1ps
`include "lfl_defines.vh"
module lfl_ctrl #(
   parameter ALL_OUT = 0,
   parameter [15:0] FILTER_TICKS = `LFL_FILTER_TICKS
) (
   clk,
   reset_n,
   en_in,
   dim_in,
   string_cfg,
   string_above_short,
   string_in_reg,
   fault_in,
   fault_out,
   fault_oe,
   string_sink_en,
   boost_en,
   bias_en,
   soft_start,
   sync_clock_output,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   irq
);
   input wire clk;
   input wire reset_n;
   input wire en_in; // Enable pin level
   input wire dim_in; // Dimming pin level
   input wire [3:0] string_cfg; // Strings in use
   input wire [3:0] string_above_short; // Pin above string_short_threshold
   input wire [3:0] string_in_reg; // Pin at regulation voltage
   input wire fault_in; // Level seen on the shared fault line
   output reg fault_out;
   output reg fault_oe;
   output reg [3:0] string_sink_en;
   output reg boost_en;
   output reg bias_en;
   output reg soft_start;
   output reg sync_clock_output;
   input wire [3:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   output reg irq;

   // ------------------------------------------------------------
   // States, one-hot
   // ------------------------------------------------------------
   localparam [3:0] ST_SLEEP = 4'h1; // Bias off, clock stopped
   localparam [3:0] ST_IDLE = 4'h2; // Awake, waiting for dimming high
   localparam [3:0] ST_SOFT = 4'h4; // Soft-start ramp
   localparam [3:0] ST_RUN = 4'h8; // Normal regulation

   localparam [15:0] TICK_DIV = `LFL_TICK_CYCLES;
   localparam [15:0] SW_DIV = `LFL_SW_DIV;
   localparam [7:0] SOFT_TICKS = `LFL_SOFT_TICKS;
   localparam [3:0] EXT_LIMIT = `LFL_EXT_FAULT_CYCLES;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   reg [3:0] state_ff; // Supervisor state
   reg [3:0] nxt_state;
   reg en_d_ff; // Enable of the previous cycle
   reg [15:0] en_low_ff; // Enable-low filter count in ticks
   reg [15:0] dim_low_ff; // Dimming-low filter count in ticks
   reg [7:0] soft_cnt_ff; // Soft-start progress in switching ticks
   reg [3:0] removed_ff; // Strings taken out of regulation
   reg fault_latch_ff; // Latched fault indication
   reg all_off_ff; // All strings latched off
   reg [3:0] ext_cnt_ff; // Switching cycles with the line held low
   reg ext_off_ff; // Disabled by another party's fault
   reg [3:0] status_ff; // Sticky event bits
   reg [3:0] mask_ff; // Interrupt mask
   reg sleep_clr; // Clear issued by wake from sleep
   reg dim_clr; // Clear issued by the dimming-low filter
   reg sleep_enter; // Enable-low filter expired
   reg [3:0] new_short; // Strings newly found shorted
   reg [3:0] ev; // Events of this cycle
   wire us_tick; // Free-running microsecond enable
   wire sw_tick; // Switching-rate enable
   wire awake; // Not in sleep
   wire lit; // Enable and dimming both high
   wire armed; // At least one string regulating

   assign awake = (state_ff != ST_SLEEP);
   assign lit = en_in && dim_in;
   assign armed = |(string_in_reg & string_cfg & ~removed_ff);

   // ------------------------------------------------------------
   // Timebases
   // ------------------------------------------------------------
   // Free-running timebase for the filters
   lfl_tick_div #(
      .DIV(TICK_DIV)
   ) u_us_div (
      .clk(clk),
      .reset_n(reset_n),
      .run(1'b1),
      .tick(us_tick)
   );

   // Switching timebase, stopped during sleep
   lfl_tick_div #(
      .DIV(SW_DIV)
   ) u_sw_div (
      .clk(clk),
      .reset_n(reset_n),
      .run(awake),
      .tick(sw_tick)
   );

   // Saturating filter count step
   function [15:0] filt_step;
      input [15:0] cnt;
      input hold;
      input step;
      begin
         if (!hold) begin
            filt_step = 16'h0000;
         end else if (step && (cnt != 16'hffff)) begin
            filt_step = cnt + 16'h0001;
         end else begin
            filt_step = cnt;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Shutdown and clear filters
   // ------------------------------------------------------------
   // Enable-low and dimming-low time counts
   always @(posedge clk) begin
      if (!reset_n) begin
         en_low_ff <= 16'h0000;
         dim_low_ff <= 16'h0000;
         en_d_ff <= 1'b0;
      end else begin
         en_low_ff <= filt_step(en_low_ff, !en_in && awake, us_tick);
         dim_low_ff <= filt_step(dim_low_ff, en_in && !dim_in && awake, us_tick);
         en_d_ff <= en_in;
      end
   end

   // Filter expiry and wake decode
   always @* begin
      sleep_enter = awake && !en_in && (en_low_ff == FILTER_TICKS) && us_tick;
      dim_clr = en_in && !dim_in && (dim_low_ff == FILTER_TICKS) && us_tick;
      sleep_clr = (state_ff == ST_SLEEP) && en_in && !en_d_ff;
   end

   // ------------------------------------------------------------
   // Supervisor state machine
   // ------------------------------------------------------------
   // Next state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SLEEP: begin
            // Wake on enable rise
            if (sleep_clr) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Ramp on the next dimming high
            if (sleep_enter) begin
               nxt_state = ST_SLEEP;
            end else if (lit) begin
               nxt_state = ST_SOFT;
            end
         end
         ST_SOFT: begin
            // Ramp to regulation
            if (sleep_enter) begin
               nxt_state = ST_SLEEP;
            end else if (dim_clr) begin
               nxt_state = ST_IDLE;
            end else if (soft_cnt_ff == SOFT_TICKS) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            // Regulate; a clear forces a fresh ramp later
            if (sleep_enter) begin
               nxt_state = ST_SLEEP;
            end else if (dim_clr) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_SLEEP;
         end
      endcase
   end

   // State register and soft-start counter
   always @(posedge clk) begin
      if (!reset_n) begin
         state_ff <= ST_SLEEP;
         soft_cnt_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         if (state_ff != ST_SOFT) begin
            soft_cnt_ff <= 8'h00;
         end else if (sw_tick && lit && (soft_cnt_ff != SOFT_TICKS)) begin
            soft_cnt_ff <= soft_cnt_ff + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Partial-short detection and fault records
   // ------------------------------------------------------------
   // Strings newly above the short threshold
   always @* begin
      new_short = 4'h0;
      if (((state_ff == ST_SOFT) || (state_ff == ST_RUN)) && lit && armed) begin
         new_short = string_above_short & string_cfg & ~removed_ff;
      end
   end

   // Fault records; detection wins over a clear in the same cycle
   always @(posedge clk) begin
      if (!reset_n) begin
         removed_ff <= 4'h0;
         fault_latch_ff <= 1'b0;
         all_off_ff <= 1'b0;
      end else begin
         if (sleep_clr || dim_clr) begin
            removed_ff <= new_short;
         end else begin
            removed_ff <= removed_ff | new_short;
         end
         if (|new_short) begin
            fault_latch_ff <= 1'b1;
         end else if (sleep_clr || (dim_clr && (ALL_OUT == 0))) begin
            fault_latch_ff <= 1'b0;
         end
         if ((ALL_OUT != 0) && (|new_short)) begin
            all_off_ff <= 1'b1;
         end else if (sleep_clr) begin
            all_off_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // External fault monitor, all-out variant only
   // ------------------------------------------------------------
   // Count switching cycles with the line held low by another party
   always @(posedge clk) begin
      if (!reset_n) begin
         ext_cnt_ff <= 4'h0;
         ext_off_ff <= 1'b0;
      end else if ((ALL_OUT == 0) || fault_in || fault_oe || !awake) begin
         ext_cnt_ff <= 4'h0;
         ext_off_ff <= 1'b0;
      end else if (sw_tick) begin
         if (ext_cnt_ff != EXT_LIMIT) begin
            ext_cnt_ff <= ext_cnt_ff + 4'h1;
         end else begin
            ext_off_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Sinks, boost, bias, soft-start flag and fault pin
   always @(posedge clk) begin
      if (!reset_n) begin
         string_sink_en <= 4'h0;
         boost_en <= 1'b0;
         bias_en <= 1'b0;
         soft_start <= 1'b0;
         fault_out <= 1'b0;
         fault_oe <= 1'b0;
      end else begin
         if (((nxt_state == ST_SOFT) || (nxt_state == ST_RUN)) && lit
             && !all_off_ff && !ext_off_ff && !(|new_short && (ALL_OUT != 0))) begin
            string_sink_en <= string_cfg & ~(removed_ff | new_short);
            boost_en <= 1'b1;
         end else begin
            string_sink_en <= 4'h0;
            boost_en <= 1'b0;
         end
         bias_en <= (nxt_state != ST_SLEEP);
         soft_start <= (nxt_state == ST_SOFT);
         fault_out <= 1'b0;
         fault_oe <= fault_latch_ff || all_off_ff || (|new_short);
      end
   end

   // Sync clock output, toggled at the switching rate while awake
   always @(posedge clk) begin
      if (!reset_n) begin
         sync_clock_output <= 1'b0;
      end else if (!awake) begin
         sync_clock_output <= 1'b0;
      end else if (sw_tick) begin
         sync_clock_output <= !sync_clock_output;
      end
   end

   // ------------------------------------------------------------
   // Event status, mask and interrupt
   // ------------------------------------------------------------
   // Events of this cycle
   always @* begin
      ev = 4'h0;
      ev[`LFL_ST_SHORT] = |new_short;
      ev[`LFL_ST_EXTF] = (ext_cnt_ff == EXT_LIMIT) && sw_tick && !ext_off_ff && !fault_in
                         && !fault_oe && (ALL_OUT != 0) && awake;
      ev[`LFL_ST_CLEAR] = sleep_clr || dim_clr;
      ev[`LFL_ST_SLEEP] = sleep_enter;
   end

   // Status cleared by its read, events win; mask written by software
   always @(posedge clk) begin
      if (!reset_n) begin
         status_ff <= `LFL_STATUS_RST;
         mask_ff <= `LFL_MASK_RST;
      end else begin
         if (reg_rd && (reg_addr == `LFL_ADDR_STATUS)) begin
            status_ff <= ev;
         end else begin
            status_ff <= status_ff | ev;
         end
         if (reg_wr && (reg_addr == `LFL_ADDR_MASK)) begin
            mask_ff <= reg_wdata[3:0];
         end
      end
   end

   // Level interrupt from unmasked sticky bits
   always @(posedge clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else if (reg_rd && (reg_addr == `LFL_ADDR_STATUS)) begin
         irq <= |(ev & mask_ff);
      end else begin
         irq <= |((status_ff | ev) & mask_ff);
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   // Read data in the cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `LFL_ADDR_STATUS) begin
         reg_rdata <= {4'h0, status_ff};
      end else if (reg_addr == `LFL_ADDR_MASK) begin
         reg_rdata <= {4'h0, mask_ff};
      end else if (reg_addr == `LFL_ADDR_STATE) begin
         reg_rdata <= {removed_ff, state_ff};
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// File: lfl_ctrl_assertions.sv
// Port-level checks of the fault latch and shutdown controller
`timescale 1ns/1ps
module lfl_ctrl_assertions #(
   parameter ALL_OUT = 0,
   parameter [15:0] FILTER_TICKS = 16'h0014
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic en_in,
   input wire logic dim_in,
   input wire logic [3:0] string_cfg,
   input wire logic [3:0] string_above_short,
   input wire logic [3:0] string_in_reg,
   input wire logic fault_in,
   input wire logic fault_out,
   input wire logic fault_oe,
   input wire logic [3:0] string_sink_en,
   input wire logic boost_en,
   input wire logic bias_en,
   input wire logic sync_clock_output
);
   // ------------------------------------------------------------
   // Run-length counters
   // ------------------------------------------------------------
   localparam int LONG = (FILTER_TICKS + 2) * 250; // Past any filter expiry
   localparam int SHORT = (FILTER_TICKS - 1) * 250; // Before any filter expiry
   localparam int EXT = 10 * 125; // Past nine switching ticks
   logic [15:0] enlo_ff; // Enable low run
   logic [15:0] off_ff; // Enable or dimming low run
   logic [15:0] ext_ff; // Foreign pull on the fault line
   logic armed; // Short detection allowed
   assign armed = en_in && dim_in && |(string_in_reg & string_cfg);
   // Saturating counts, cleared when the condition ends
   always @(posedge clk) begin
      if (!reset_n) begin
         enlo_ff <= 16'h0000;
         off_ff <= 16'h0000;
         ext_ff <= 16'h0000;
      end else begin
         enlo_ff <= en_in ? 16'h0000 : enlo_ff + 16'(enlo_ff < LONG);
         off_ff <= (en_in && dim_in) ? 16'h0000 : off_ff + 16'(off_ff < LONG);
         ext_ff <= (fault_in || fault_oe) ? 16'h0000 : ext_ff + 16'(ext_ff < EXT);
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_sinks_need_pair: assert property ((!(en_in && dim_in))[*3] |-> string_sink_en == 4'h0)
      else $error("sinks on without enable and dimming");
   a_sleep_after_filter: assert property (enlo_ff >= LONG |-> !bias_en && !sync_clock_output)
      else $error("still awake after long enable low");
   a_bias_with_enable: assert property (en_in[*3] |-> bias_en)
      else $error("bias off while enable high");
   a_fault_has_cause: assert property ($rose(fault_oe) |-> !fault_out &&
      ($past(|string_above_short) || $past(|string_above_short, 2)))
      else $error("fault pulled without a short");
   a_short_removed: assert property (armed && |(string_above_short & string_sink_en) |=>
      (ALL_OUT != 0 ? (string_sink_en == 4'h0 && !boost_en)
      : (string_sink_en & $past(string_above_short)) == 4'h0))
      else $error("shorted string kept in regulation");
   a_unarmed_ignored: assert property ((!(|(string_in_reg & string_cfg)) && !fault_oe)[*2] |=>
      !fault_oe)
      else $error("short flagged with no string regulating");
   a_ext_disables: assert property (ALL_OUT != 0 && ext_ff >= EXT |->
      !boost_en && string_sink_en == 4'h0)
      else $error("foreign fault did not disable");
   a_latch_held: assert property ($past(reset_n) && $fell(fault_oe) |->
      $past(off_ff) >= SHORT || $past(off_ff, 2) >= SHORT)
      else $error("fault released before filter time");
   cover property ($rose(fault_oe));
   cover property (ALL_OUT != 0 && ext_ff >= EXT);
   cover property ($fell(bias_en));
   cover property ($fell(fault_oe) && bias_en);
endmodule
bind lfl_ctrl lfl_ctrl_assertions #(.ALL_OUT(ALL_OUT), .FILTER_TICKS(FILTER_TICKS)) u_chk (.*);

// File: lfl_sys_model.sv
// Shared fault lines with pull-up and a foreign driver
`timescale 1ns/1ps
module lfl_sys_model (
   input wire logic [1:0] fault_oe,
   input wire logic [1:0] fault_out,
   input wire logic ext_pull,
   output logic [1:0] fault_in
);
   // One wired-AND line: pull-up wins unless any device or the foreign party pulls low
   assign fault_in = {2{(&(~fault_oe | fault_out)) && !ext_pull}};
endmodule

// File: testbench.sv
// Self-checking bench, standard and all-out controllers side by side
`timescale 1ns/1ps
module testbench;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int FT = 20; // Filter in timebase ticks
   localparam int TK = 250; // Clocks per timebase tick
   localparam int SW = 125; // Clocks per switching tick
   logic clk = 1'b0, reset_n = 1'b0, en_in = 1'b0, dim_in = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ext_pull = 1'b0;
   logic [3:0] cfg = 4'h0, sas = 4'h0, sir = 4'h0, reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, w;
   logic [1:0] prev;
   wire [1:0] fin, fout, foe, boost, bias, ss, sco, irq;
   wire [3:0] sink [2];
   wire [7:0] rdat [2];
   int bad_count = 0, num_checks = 0, k, i, j;
   logic [7:0] rst_tab [4] = '{8'h00, 8'h00, 8'h01, 8'h00}; // Reset image per address
   always #2 clk = ~clk;
   genvar g;
   for (g = 0; g < 2; g++) begin : gi
      lfl_ctrl #(.ALL_OUT(g), .FILTER_TICKS(16'h0014)) i_lfl_ctrl (
         .clk(clk), .reset_n(reset_n), .en_in(en_in), .dim_in(dim_in), .string_cfg(cfg),
         .string_above_short(sas), .string_in_reg(sir), .fault_in(fin[g]), .fault_out(fout[g]),
         .fault_oe(foe[g]), .string_sink_en(sink[g]), .boost_en(boost[g]), .bias_en(bias[g]),
         .soft_start(ss[g]), .sync_clock_output(sco[g]), .reg_addr(reg_addr),
         .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat[g]),
         .irq(irq[g]));
   end
   lfl_sys_model i_lfl_sys_model (.fault_oe(foe), .fault_out(fout), .ext_pull(ext_pull),
      .fault_in(fin));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] left(input logic [3:0] c, input int s, input int all);
      return all ? 4'h0 : c & ~(4'h1 << s);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic smp(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic wait_run();
      for (k = 0; k < 20000 && ss !== 2'b00; k++) smp(1);
      if (k == 20000) begin
         bad_count++;
         conclude();
      end
   endtask
   task automatic done(input string s);
      $display("test %0s finished", s);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(100000);
      bad_count++;
      conclude();
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      k = $urandom(98176);
      i = $urandom_range(3);
      j = (i + 1) % 4;
      cfg = (4'h1 << i) | (4'h1 << j) | 4'($urandom);
      sir = cfg;
      cyc(6);
      reset_n <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd(4'(a * 4));
         chk(rdat[0], rst_tab[a]);
         chk(rdat[1], rst_tab[a]);
      end
      w = 8'($urandom);
      wr(4'h4, w);
      wr(4'h0, 8'hff);
      wr(4'hc, w);
      rd(4'h4);
      chk(rdat[1], {4'h0, w[3:0]});
      rd(4'h0);
      chk(rdat[0], 8'h00);
      wr(4'h4, 8'h0f);
      done("registers");
      en_in <= 1'b1;
      smp(3);
      chk(bias, 2'b11);
      chk(irq, 2'b11);
      rd(4'h0);
      chk(rdat[0], 8'h04);
      smp(1);
      chk(irq, 2'b00);
      cyc(1);
      dim_in <= 1'b1;
      smp(2);
      chk(ss, 2'b11);
      chk(sink[1], cfg);
      wait_run();
      done("wake");
      repeat (8) begin
         cyc(1);
         dim_in <= 1'b0;
         smp(3 + $urandom_range(5));
         chk(sink[0], 4'h0);
         cyc(1);
         dim_in <= 1'b1;
         smp(3 + $urandom_range(20));
         chk(sink[1], cfg);
      end
      cyc(1);
      sir <= 4'h0;
      sas <= 4'h1 << i;
      smp(4);
      chk(foe, 2'b00);
      chk(sink[0], cfg);
      cyc(1);
      sir <= 4'h1 << j;
      smp(2);
      for (int n = 0; n < 2; n++) chk(sink[n], left(cfg, i, n));
      chk(foe, 2'b11);
      chk(boost, 2'b01);
      rd(4'h0);
      chk(rdat[0], 8'h01);
      cyc(1);
      sas <= 4'h0;
      smp(3);
      chk(foe, 2'b11);
      done("short");
      cyc(1);
      dim_in <= 1'b0;
      smp((FT + 3) * TK);
      chk(foe, 2'b10);
      prev = sco;
      smp(SW);
      chk(sco ^ prev, 2'b11);
      cyc(1);
      dim_in <= 1'b1;
      smp(2);
      chk(ss[0], 1'b1);
      chk(sink[0], cfg);
      wait_run();
      done("dim clear");
      cyc(1);
      en_in <= 1'b0;
      dim_in <= 1'b0;
      smp((FT - 1) * TK - 5);
      chk(bias, 2'b11);
      smp(4 * TK);
      chk(bias | sco, 2'b00);
      rd(4'h0);
      chk(rdat[0] & 8'h08, 8'h08);
      cyc(1);
      en_in <= 1'b1;
      smp(3);
      chk(foe | ss, 2'b00);
      rd(4'h8);
      chk(rdat[0], 8'h02);
      chk(rdat[1], 8'h02);
      cyc(1);
      dim_in <= 1'b1;
      smp(2);
      chk(ss, 2'b11);
      wait_run();
      done("sleep");
      cyc(1);
      ext_pull <= 1'b1;
      cyc(5 * SW);
      ext_pull <= 1'b0;
      smp(2);
      chk(boost, 2'b11);
      cyc(1);
      ext_pull <= 1'b1;
      smp(10 * SW + 3);
      chk(boost, 2'b01);
      chk(sink[1], 4'h0);
      rd(4'h0);
      chk(rdat[1] & 8'h02, 8'h02);
      cyc(1);
      ext_pull <= 1'b0;
      done("external fault");
      conclude();
   end
endmodule
